// file: rtl/dtc_pkg.sv
// constants shared by the dual timer and capture unit
package dtc_pkg;

   // ************************************************
   // register word offsets (byte addresses)
   // ************************************************
   localparam logic [7:0] OFS_PRESCALER = 8'h00;
   localparam logic [7:0] OFS_CLOCK_SEL = 8'h04;
   localparam logic [7:0] OFS_COUNTER_ONE = 8'h08;
   localparam logic [7:0] OFS_COUNTER_TWO = 8'h0c;
   localparam logic [7:0] OFS_RELOAD_A = 8'h10;
   localparam logic [7:0] OFS_RELOAD_B = 8'h14;
   localparam logic [7:0] OFS_MODE_CTRL = 8'h18;
   localparam logic [7:0] OFS_IRQ_CTRL = 8'h1c;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;

   // ************************************************
   // field positions
   // ************************************************
   localparam int CKC_C1_LSB = 0;
   localparam int CKC_C2_LSB = 3;
   localparam int CTL_MODE_LSB = 0;
   localparam int CTL_A_EDGE = 2;
   localparam int CTL_B_EDGE = 3;
   localparam int CTL_A_EN = 4;
   localparam int CTL_B_EN = 5;
   localparam int CTL_A_OUT = 6;
   localparam int ICR_PEND_LSB = 0;
   localparam int ICR_IEN_LSB = 4;

   // ************************************************
   // reset values and encodings
   // ************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [4:0] PRE_ZERO = 5'h00;

   // mode field encodings
   localparam logic [1:0] MODE_PWM = 2'h0;
   localparam logic [1:0] MODE_DUAL_CAP = 2'h1;
   localparam logic [1:0] MODE_DUAL_TMR = 2'h2;
   localparam logic [1:0] MODE_CAP_TMR = 2'h3;

   // counter clock select encodings
   localparam logic [2:0] CSEL_STOP = 3'h0;
   localparam logic [2:0] CSEL_PRESCALED = 3'h1;
   localparam logic [2:0] CSEL_EXT_EVENT = 3'h2;
   localparam logic [2:0] CSEL_PULSE_ACC = 3'h3;
   localparam logic [2:0] CSEL_SLOW = 3'h4;

   // system interrupt line numbers per unit
   localparam logic [3:0] IRQ_U1_LINE_I = 4'hd;
   localparam logic [3:0] IRQ_U1_LINE_II = 4'hc;
   localparam logic [3:0] IRQ_U2_LINE_I = 4'hb;
   localparam logic [3:0] IRQ_U2_LINE_II = 4'ha;

endpackage

// file: rtl/dtc_timer_unit.sv
// dual 16-bit down-counter timer unit with capture, behind ahb-lite
// Notes on behaviour
// [R1] dual timer: counter one reloads from a
// [R2] modes 3/4: pin a toggles on underflow
// [R3] pin a rising toggle sets pending c
// [R4] dual timer: counter two reloads from b
// [R5] dual timer: counter two underflow sets d
// [R6] pin b usable as event/accumulate clock
// [R7] single capture: pin b edge captures two
// [R8] pin b edge polarity is programmable
// [R9] capture stores first, then presets all ones
// [R10] pin b enable adds preset to capture
// [R11] source holds pin b pulses one cycle
// [R12] capture sets b, underflow sets d
// [R13] capture modes: pin b clocks stop counters
// [R14] software keeps counter two clocked
// [R15] sources a-c on irq i, d on ii
// [R16] each source own enable and pending
// [R17] unit selects its interrupt line numbers
// [R18] dual capture: a/b captures, c/d underflows
// [R19] pwm: a/b reloads, d underflow
// [R20] dual timer: a reload a, d reload b
// [R21] dual capture: pin a captures, presets
// [R22] pin a start level from output bit
// [R23] two-bit field selects four modes
// [R24] pending cleared only via clear register
// [R25] output bit writable, software write wins
// [R26] three-bit clock select per counter
// [R27] irq line set while pending and enabled
`timescale 1ns/1ps
module dtc_timer_unit
   import dtc_pkg::*;
#(
   parameter bit UNIT_TWO = 1'b0
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // timer pins and slow clock
   input wire logic i_timer_pin_a,
   output logic o_timer_pin_a,
   output logic o_timer_pin_a_oe_n,
   input wire logic i_timer_pin_b,
   input wire logic i_slow_clk,
   // system interrupts
   output logic o_unit_interrupt_i,
   output logic o_unit_interrupt_ii,
   output logic [3:0] o_irq_line_i,
   output logic [3:0] o_irq_line_ii
);

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [2:0] sync1_reg, sync2_reg, prev_reg;
   wire [2:0] raw_in = {i_slow_clk, i_timer_pin_b, i_timer_pin_a};
   // two flops per input, third flop only for edge detection
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
               sync1_reg[g] <= 1'b0;
               sync2_reg[g] <= 1'b0;
               prev_reg[g] <= 1'b0;
            end else begin
               sync1_reg[g] <= raw_in[g];
               sync2_reg[g] <= sync1_reg[g];
               prev_reg[g] <= sync2_reg[g];
            end
         end
      end
   endgenerate

   // ************************************************
   // registers
   // ************************************************
   logic [4:0] prescaler_reg, pre_cnt_reg;
   logic [7:0] clock_select_reg, mode_control_reg, irq_control_reg;
   logic [15:0] down_counter_one_reg, down_counter_two_reg;
   logic [15:0] reload_capture_a_reg, reload_capture_b_reg;
   logic pwm_from_b_reg, irq_i_reg, irq_ii_reg;
   logic dp_wr_reg, dp_rd_reg, rd_ready_reg;
   logic [7:0] dp_addr_reg;
   logic [31:0] hrdata_reg;
   // ************************************************
   // ahb-lite slave
   // ************************************************
   wire addr_phase = i_hsel & i_htrans[1] & i_hready;
   wire wr_prsc = dp_wr_reg & (dp_addr_reg == OFS_PRESCALER);
   wire wr_ckc = dp_wr_reg & (dp_addr_reg == OFS_CLOCK_SEL);
   wire wr_cnt1 = dp_wr_reg & (dp_addr_reg == OFS_COUNTER_ONE);
   wire wr_cnt2 = dp_wr_reg & (dp_addr_reg == OFS_COUNTER_TWO);
   wire wr_cra = dp_wr_reg & (dp_addr_reg == OFS_RELOAD_A);
   wire wr_crb = dp_wr_reg & (dp_addr_reg == OFS_RELOAD_B);
   wire wr_ctrl = dp_wr_reg & (dp_addr_reg == OFS_MODE_CTRL);
   wire wr_icr = dp_wr_reg & (dp_addr_reg == OFS_IRQ_CTRL);
   wire wr_iclr = dp_wr_reg & (dp_addr_reg == OFS_IRQ_CLEAR);

   // read mux, unmapped and write-only words read zero
   logic [31:0] rd_mux;
   always_comb begin
      if (dp_addr_reg == OFS_PRESCALER) begin
         rd_mux = {27'h0000000, prescaler_reg};
      end else if (dp_addr_reg == OFS_CLOCK_SEL) begin
         rd_mux = {24'h000000, clock_select_reg};
      end else if (dp_addr_reg == OFS_COUNTER_ONE) begin
         rd_mux = {16'h0000, down_counter_one_reg};
      end else if (dp_addr_reg == OFS_COUNTER_TWO) begin
         rd_mux = {16'h0000, down_counter_two_reg};
      end else if (dp_addr_reg == OFS_RELOAD_A) begin
         rd_mux = {16'h0000, reload_capture_a_reg};
      end else if (dp_addr_reg == OFS_RELOAD_B) begin
         rd_mux = {16'h0000, reload_capture_b_reg};
      end else if (dp_addr_reg == OFS_MODE_CTRL) begin
         rd_mux = {24'h000000, mode_control_reg};
      end else if (dp_addr_reg == OFS_IRQ_CTRL) begin
         rd_mux = {24'h000000, irq_control_reg};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   // reads take one wait state so they see the latest write
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         dp_wr_reg <= 1'b0;
         dp_rd_reg <= 1'b0;
         rd_ready_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end else begin
         if (o_hreadyout) begin
            dp_wr_reg <= addr_phase & i_hwrite;
            dp_rd_reg <= addr_phase & ~i_hwrite;
            dp_addr_reg <= addr_phase ? i_haddr[7:0] : dp_addr_reg;
         end
         rd_ready_reg <= dp_rd_reg & ~rd_ready_reg;
         if (dp_rd_reg & ~rd_ready_reg) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   assign o_hreadyout = ~(dp_rd_reg & ~rd_ready_reg);
   assign o_hrdata = hrdata_reg;
   assign o_hresp = 1'b0;
   // ************************************************
   // field decode and clock sources
   // ************************************************
   wire [1:0] mode_field = mode_control_reg[CTL_MODE_LSB +: 2];
   wire [2:0] counter_one_clock_select = clock_select_reg[CKC_C1_LSB +: 3];
   wire [2:0] counter_two_clock_select = clock_select_reg[CKC_C2_LSB +: 3];
   wire pin_a_enable = mode_control_reg[CTL_A_EN];
   wire pin_b_enable = mode_control_reg[CTL_B_EN];
   wire pin_a_output_level = mode_control_reg[CTL_A_OUT];
   wire a_pol = mode_control_reg[CTL_A_EDGE];
   wire b_pol = mode_control_reg[CTL_B_EDGE];
   wire [3:0] pend = irq_control_reg[ICR_PEND_LSB +: 4];
   wire [3:0] ien = irq_control_reg[ICR_IEN_LSB +: 4];
   wire mode_pwm = (mode_field == MODE_PWM); // R23
   wire mode_dcap = (mode_field == MODE_DUAL_CAP);
   wire mode_dtmr = (mode_field == MODE_DUAL_TMR);
   wire mode_ctmr = (mode_field == MODE_CAP_TMR);
   wire cap_mode = mode_field[0];
   wire pin_b_lvl = sync2_reg[1];
   // edges chosen by the polarity bits
   wire a_edge = a_pol ? (sync2_reg[0] & ~prev_reg[0])
      : (~sync2_reg[0] & prev_reg[0]);
   wire b_edge = b_pol ? (sync2_reg[1] & ~prev_reg[1])
      : (~sync2_reg[1] & prev_reg[1]); // R8
   wire slow_rise = sync2_reg[2] & ~prev_reg[2];
   wire pre_tick = (pre_cnt_reg == prescaler_reg);

   // counter tick from its clock select; pin b sources die in capture
   function automatic logic tick_of(input logic [2:0] csel,
         input logic capm, input logic pre, input logic bedge,
         input logic bmatch, input logic slow);
      logic t;
      t = 1'b0;
      case (csel) // R26
         CSEL_PRESCALED: t = pre;
         CSEL_EXT_EVENT: t = ~capm & bedge; // R6 R13
         CSEL_PULSE_ACC: t = ~capm & pre & bmatch; // R6 R13
         CSEL_SLOW: t = slow;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   wire b_match = (pin_b_lvl == b_pol);
   wire tick1 = tick_of(counter_one_clock_select, cap_mode, pre_tick,
      b_edge, b_match, slow_rise);
   wire tick2 = tick_of(counter_two_clock_select, cap_mode, pre_tick,
      b_edge, b_match, slow_rise);
   wire uf1 = tick1 & (down_counter_one_reg == CNT_ZERO);
   wire uf2 = tick2 & (down_counter_two_reg == CNT_ZERO);
   // pin a captures only in dual capture, pin b in both capture modes
   wire cap_a = mode_dcap & a_edge; // R21
   wire cap_b = cap_mode & b_edge; // R7
   wire toggle_a = pin_a_enable & uf1 & ~mode_dcap; // R2
   wire rise_a = toggle_a & ~pin_a_output_level & mode_field[1]; // R3

   // ************************************************
   // counters
   // ************************************************
   logic [15:0] cnt1_next, cnt2_next;
   always_comb begin
      cnt1_next = down_counter_one_reg;
      if (wr_cnt1) begin
         cnt1_next = i_hwdata[15:0];
      end else if ((cap_a & pin_a_enable) | (mode_dcap & b_edge
            & pin_b_enable)) begin
         cnt1_next = CNT_ALL_ONES; // R21 R10
      end else if (uf1) begin
         if (mode_pwm) begin
            cnt1_next = pwm_from_b_reg ? reload_capture_b_reg
               : reload_capture_a_reg;
         end else if (mode_dcap) begin
            cnt1_next = CNT_ALL_ONES;
         end else begin
            cnt1_next = reload_capture_a_reg; // R1
         end
      end else if (tick1) begin
         cnt1_next = down_counter_one_reg - 16'h0001;
      end
   end

   always_comb begin
      cnt2_next = down_counter_two_reg;
      if (wr_cnt2) begin
         cnt2_next = i_hwdata[15:0];
      end else if (mode_ctmr & cap_b & pin_b_enable) begin
         cnt2_next = CNT_ALL_ONES; // R9 R10
      end else if (uf2) begin
         cnt2_next = mode_dtmr ? reload_capture_b_reg : CNT_ALL_ONES; // R4
      end else if (tick2) begin
         cnt2_next = down_counter_two_reg - 16'h0001;
      end
   end
   // capture takes the count before any preset of the same edge
   wire [15:0] cra_next = wr_cra ? i_hwdata[15:0]
      : cap_a ? down_counter_one_reg : reload_capture_a_reg;
   wire [15:0] crb_next = wr_crb ? i_hwdata[15:0]
      : (mode_dcap & b_edge) ? down_counter_one_reg
      : (mode_ctmr & b_edge) ? down_counter_two_reg // R7 R9
      : reload_capture_b_reg;

   // ************************************************
   // pending flags and interrupts
   // ************************************************
   wire set_a = (mode_pwm & uf1 & ~pwm_from_b_reg) | cap_a
      | (mode_field[1] & uf1); // R19 R18 R20
   wire set_b = (mode_pwm & uf1 & pwm_from_b_reg) | cap_b; // R12 R18
   wire set_c = (mode_dcap & uf1) | rise_a; // R3 R18
   wire set_d = uf2; // R5 R12
   wire [3:0] hw_set = {set_d, set_c, set_b, set_a};
   wire [3:0] sw_set = wr_icr ? i_hwdata[3:0] : 4'h0;
   wire [3:0] sw_clr = wr_iclr ? i_hwdata[3:0] : 4'h0;
   // zero writes ignored, clears lose to a same-cycle event
   wire [3:0] pend_next = ((pend | sw_set) & ~sw_clr) | hw_set; // R24 R16
   wire [3:0] ien_next = wr_icr ? i_hwdata[7:4] : ien;
   // c also answers to enable a while pin a drives it
   wire irq_i_next = |(pend[2:0] & ien[2:0])
      | (mode_field[1] & pend[2] & ien[0]); // R15 R27 R3
   wire irq_ii_next = pend[3] & ien[3]; // R15 R27
   // pin a level: software write wins over a hardware toggle
   wire aout_next = wr_ctrl ? i_hwdata[CTL_A_OUT]
      : toggle_a ? ~pin_a_output_level : pin_a_output_level; // R25 R22
   wire [7:0] ctrl_next = wr_ctrl ? {1'b0, aout_next, i_hwdata[5:0]}
      : {1'b0, aout_next, mode_control_reg[5:0]};
   // alternation restarts from a whenever pwm stops
   wire pwm_b_next = (~mode_pwm | (counter_one_clock_select == CSEL_STOP))
      ? 1'b0 : (uf1 ? ~pwm_from_b_reg : pwm_from_b_reg);

   // control and status registers
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         prescaler_reg <= PRE_ZERO;
         clock_select_reg <= RST_BYTE;
         mode_control_reg <= RST_BYTE;
         irq_control_reg <= RST_BYTE;
         pre_cnt_reg <= PRE_ZERO;
         pwm_from_b_reg <= 1'b0;
         irq_i_reg <= 1'b0;
         irq_ii_reg <= 1'b0;
      end else begin
         prescaler_reg <= wr_prsc ? i_hwdata[4:0] : prescaler_reg;
         clock_select_reg <= wr_ckc ? {2'h0, i_hwdata[5:0]}
            : clock_select_reg;
         mode_control_reg <= ctrl_next;
         irq_control_reg <= {ien_next, pend_next};
         pre_cnt_reg <= pre_tick ? PRE_ZERO : pre_cnt_reg + 5'h01;
         pwm_from_b_reg <= pwm_b_next;
         irq_i_reg <= irq_i_next;
         irq_ii_reg <= irq_ii_next;
      end
   end
   // count and capture words keep no reset value
   always_ff @(posedge i_clk_sys) begin
      down_counter_one_reg <= cnt1_next;
      down_counter_two_reg <= cnt2_next;
      reload_capture_a_reg <= cra_next;
      reload_capture_b_reg <= crb_next;
   end

   // ************************************************
   // outputs
   // ************************************************
   assign o_timer_pin_a = pin_a_output_level;
   assign o_timer_pin_a_oe_n = ~(pin_a_enable & ~mode_dcap);
   assign o_unit_interrupt_i = irq_i_reg;
   assign o_unit_interrupt_ii = irq_ii_reg;
   assign o_irq_line_i = UNIT_TWO ? IRQ_U2_LINE_I : IRQ_U1_LINE_I; // R17
   assign o_irq_line_ii = UNIT_TWO ? IRQ_U2_LINE_II : IRQ_U1_LINE_II;

   // ************************************************
   // assertions
   // ************************************************
   chk_reload_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R1
      mode_dtmr & uf1 & ~wr_cnt1 & ~wr_ctrl |=>
      down_counter_one_reg == $past(reload_capture_a_reg))
      else $error("counter one did not reload from a");
   chk_toggle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R2
      mode_field[1] & pin_a_enable & uf1 & ~wr_ctrl |=>
      o_timer_pin_a != $past(o_timer_pin_a))
      else $error("pin a did not toggle on underflow");
   chk_rise_c: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R3
      rise_a |=> pend[2])
      else $error("rising toggle did not set pending c");
   chk_reload_b: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R4
      mode_dtmr & uf2 & ~wr_cnt2 & ~wr_ctrl |=>
      down_counter_two_reg == $past(reload_capture_b_reg))
      else $error("counter two did not reload from b");
   chk_pend_d: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R5
      uf2 |=> pend[3] ##1 (irq_ii_reg == $past(ien[3])))
      else $error("underflow two did not set pending d");
   chk_capture_b: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R9
      mode_ctmr & b_edge & pin_b_enable & ~wr_crb & ~wr_cnt2 & ~wr_ctrl
      |=> reload_capture_b_reg == $past(down_counter_two_reg)
      && down_counter_two_reg == CNT_ALL_ONES)
      else $error("capture b did not store then preset");
   chk_stop_cap: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R13
      cap_mode & (counter_one_clock_select == CSEL_EXT_EVENT) & ~wr_cnt1
      & ~b_edge & ~cap_a & ~wr_ctrl |=> $stable(down_counter_one_reg))
      else $error("counter one ran on pin b in capture mode");
   chk_pend_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R24
      pend[0] & ~(wr_iclr & i_hwdata[0]) |=> pend[0])
      else $error("pending a lost without a clear");
   chk_irq_i_map: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R27
      (pend[0] & ien[0]) ##1 (pend[0] & ien[0])
      |-> irq_i_reg)
      else $error("interrupt i missing for pending a");

endmodule

// file: verification/dtc_pin_model.sv
// external sources and load on the two timer pins and the slow clock
`timescale 1ns/1ps
module dtc_pin_model (
   // clock
   input wire logic i_clk_sys,
   // pin a as driven by the unit
   input wire logic i_pin_a_out,
   input wire logic i_pin_a_oe_n,
   // resolved pin a, pin b source, slow clock source
   output logic o_pin_a_wire,
   output logic o_timer_pin_b,
   output logic o_slow_clk
);
   logic pin_a_src = 1'b0;
   // the unit wins while it drives pin a, else the far source shows
   assign o_pin_a_wire = i_pin_a_oe_n ? pin_a_src : i_pin_a_out;
   initial begin
      o_timer_pin_b = 1'b0;
      o_slow_clk = 1'b0;
   end
   // put a level on pin b and keep it for whole clocks
   task automatic drive_b(input logic lvl, input int hold);
      o_timer_pin_b <= lvl;
      repeat (hold) @(posedge i_clk_sys);
   endtask
   // far source level on pin a, seen only while the unit leaves it free
   task automatic drive_a(input logic lvl, input int hold);
      pin_a_src <= lvl;
      repeat (hold) @(posedge i_clk_sys);
   endtask
   // slow clock rises, at an eighth of the system rate
   task automatic slow_ticks(input int n);
      repeat (n) begin
         o_slow_clk <= 1'b1;
         repeat (4) @(posedge i_clk_sys);
         o_slow_clk <= 1'b0;
         repeat (4) @(posedge i_clk_sys);
      end
   endtask
endmodule

// file: verification/test_dual_timer_capture_modes.sv
// self-checking bench for the dual timer and capture unit
`timescale 1ns/1ps
module test_dual_timer_capture_modes
   import dtc_pkg::*;
;
   // ****************************************
   // signals, clock and instances
   // ****************************************
   logic clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, pin_a_out, pin_a_oe_n, pin_a_wire, pin_b;
   logic slow_clk, int_i, int_ii;
   logic [3:0] line_i, line_ii;
   int fails = 0, checks = 0;
   // free running system clock
   always #20 clk_sys = ~clk_sys;
   dtc_timer_unit #(.UNIT_TWO(1'b0)) dut (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp),
      .i_timer_pin_a(pin_a_wire), .o_timer_pin_a(pin_a_out),
      .o_timer_pin_a_oe_n(pin_a_oe_n), .i_timer_pin_b(pin_b),
      .i_slow_clk(slow_clk), .o_unit_interrupt_i(int_i),
      .o_unit_interrupt_ii(int_ii), .o_irq_line_i(line_i),
      .o_irq_line_ii(line_ii));
   dtc_pin_model model (
      .i_clk_sys(clk_sys), .i_pin_a_out(pin_a_out),
      .i_pin_a_oe_n(pin_a_oe_n), .o_pin_a_wire(pin_a_wire),
      .o_timer_pin_b(pin_b), .o_slow_clk(slow_clk));
   // ****************************************
   // bus, wait and compare tasks
   // ****************************************
   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // let n edges pass, then step past the edge so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one single ahb-lite transfer, driven just after a rising edge;
   // ready and read data are read as that edge sampled them
   task automatic bus(input logic [7:0] a, input logic wr,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      chk(r, exp);
   endtask
   // cycles until pin a changes level, bounded
   task automatic wait_a(output int n);
      logic l;
      l = pin_a_wire;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (pin_a_wire === l && n < 50);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      logic [7:0] ofs [6];
      ofs = '{OFS_PRESCALER, OFS_CLOCK_SEL, OFS_MODE_CTRL, OFS_IRQ_CTRL,
              OFS_IRQ_CLEAR, 8'h40};
      foreach (ofs[i]) rdchk(ofs[i], 32'h0);
      chk(32'({pin_a_oe_n, int_i, int_ii, hresp}), 32'h8);
      chk(32'({line_i, line_ii}), 32'hdc);
   endtask
   task automatic t_irq;
      wr(OFS_IRQ_CTRL, 32'h0f);
      cyc(2);
      chk(32'({int_i, int_ii}), 32'h0);
      wr(OFS_IRQ_CTRL, 32'h1f);
      cyc(2);
      chk(32'({int_i, int_ii}), 32'h2);
      wr(OFS_IRQ_CTRL, 32'h80);
      cyc(2);
      chk(32'({int_i, int_ii}), 32'h1);
      rdchk(OFS_IRQ_CTRL, 32'h8f);
      wr(OFS_IRQ_CLEAR, 32'h0f);
      rdchk(OFS_IRQ_CTRL, 32'h80);
      cyc(2);
      chk(32'(int_ii), 32'h0);
   endtask
   task automatic t_timer_one;
      int n;
      wr(OFS_IRQ_CTRL, 32'h40);
      wr(OFS_RELOAD_A, 32'h3);
      wr(OFS_COUNTER_ONE, 32'h3);
      wr(OFS_MODE_CTRL, 32'h52);
      cyc(2);
      chk(32'({pin_a_oe_n, pin_a_wire}), 32'h1);
      wr(OFS_CLOCK_SEL, 32'h01);
      wait_a(n);
      wait_a(n);
      chk(n, 4);
      wait_a(n);
      chk(n, 4);
      rdchk(OFS_IRQ_CTRL, 32'h45);
      chk(32'(int_i), 32'h1);
      wr(OFS_CLOCK_SEL, 32'h0);
      wr(OFS_IRQ_CLEAR, 32'h0f);
   endtask
   task automatic t_timer_two;
      logic [31:0] r;
      wr(OFS_COUNTER_TWO, 32'h0);
      wr(OFS_RELOAD_B, 32'h5);
      wr(OFS_IRQ_CTRL, 32'h80);
      wr(OFS_CLOCK_SEL, 32'h08);
      cyc(3);
      chk(32'({int_i, int_ii}), 32'h1);
      wr(OFS_CLOCK_SEL, 32'h0);
      bus(OFS_COUNTER_TWO, 1'b0, 32'h0, r);
      chk(32'(r <= 32'h5), 32'h1);
      rdchk(OFS_IRQ_CTRL, 32'h88);
      wr(OFS_IRQ_CLEAR, 32'h0f);
   endtask
   task automatic t_ext_clock;
      wr(OFS_MODE_CTRL, 32'h0a);
      wr(OFS_COUNTER_TWO, 32'h10);
      wr(OFS_CLOCK_SEL, 32'h10);
      repeat (3) begin
         model.drive_b(1'b1, 2);
         model.drive_b(1'b0, 2);
      end
      cyc(4);
      rdchk(OFS_COUNTER_TWO, 32'h0d);
      wr(OFS_CLOCK_SEL, 32'h18);
      cyc(8);
      rdchk(OFS_COUNTER_TWO, 32'h0d);
      wr(OFS_CLOCK_SEL, 32'h20);
      model.slow_ticks(2);
      cyc(4);
      rdchk(OFS_COUNTER_TWO, 32'h0b);
      wr(OFS_CLOCK_SEL, 32'h0);
   endtask
   task automatic t_capture;
      wr(OFS_CLOCK_SEL, 32'h20);
      wr(OFS_IRQ_CTRL, 32'h20);
      wr(OFS_MODE_CTRL, 32'h0b);
      wr(OFS_COUNTER_TWO, 32'h1234);
      model.drive_b(1'b1, 2);
      model.drive_b(1'b0, 4);
      rdchk(OFS_RELOAD_B, 32'h1234);
      rdchk(OFS_COUNTER_TWO, 32'h1234);
      rdchk(OFS_IRQ_CTRL, 32'h22);
      chk(32'(int_i), 32'h1);
      wr(OFS_MODE_CTRL, 32'h23);
      wr(OFS_COUNTER_TWO, 32'h42);
      wr(OFS_COUNTER_ONE, 32'h7);
      wr(OFS_CLOCK_SEL, 32'h22);
      model.drive_b(1'b1, 4);
      rdchk(OFS_RELOAD_B, 32'h1234);
      model.drive_b(1'b0, 4);
      rdchk(OFS_RELOAD_B, 32'h42);
      rdchk(OFS_COUNTER_TWO, 32'hffff);
      rdchk(OFS_COUNTER_ONE, 32'h7);
   endtask
   task automatic t_dual_cap;
      wr(OFS_MODE_CTRL, 32'h15);
      wr(OFS_CLOCK_SEL, 32'h0);
      wr(OFS_IRQ_CLEAR, 32'h0f);
      wr(OFS_COUNTER_ONE, 32'h99);
      model.drive_a(1'b1, 4);
      rdchk(OFS_RELOAD_A, 32'h99);
      rdchk(OFS_COUNTER_ONE, 32'hffff);
      rdchk(OFS_IRQ_CTRL, 32'h21);
      wr(OFS_COUNTER_ONE, 32'h0);
      wr(OFS_CLOCK_SEL, 32'h01);
      cyc(3);
      rdchk(OFS_IRQ_CTRL, 32'h25);
      chk(32'(pin_a_oe_n), 32'h1);
   endtask
   task automatic t_pwm;
      int n;
      wr(OFS_CLOCK_SEL, 32'h0);
      wr(OFS_IRQ_CLEAR, 32'h0f);
      wr(OFS_RELOAD_A, 32'h2);
      wr(OFS_RELOAD_B, 32'h5);
      wr(OFS_COUNTER_ONE, 32'h0);
      wr(OFS_MODE_CTRL, 32'h10);
      wr(OFS_CLOCK_SEL, 32'h01);
      wait_a(n);
      wait_a(n);
      chk(n, 3);
      wait_a(n);
      chk(n, 6);
      rdchk(OFS_IRQ_CTRL, 32'h23);
      wr(OFS_CLOCK_SEL, 32'h0);
   endtask
   // main sequence: reset, then every scenario in turn
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset;
      t_irq;
      t_timer_one;
      t_timer_two;
      t_ext_clock;
      t_capture;
      t_dual_cap;
      t_pwm;
      test_done;
   end
   // watchdog: the whole run needs well under 3000 clocks
   initial begin
      #400000;
      fails++;
      test_done;
   end
endmodule
